/* File: rtl/cdr_pkg.sv */
// Shared constants and carrier types for the cached DRAM host controller.
// Assumes a 25 MHz host clock and a cached EDO DRAM module on the pins.
package cdr_pkg;

	// Data path and address widths of the module
	localparam int DQ_W = 72;
	localparam int ADDR_W = 11;
	localparam int COL_W = 8;
	localparam int REF_ROW_W = 10;

	// Host clock period in ns
	localparam int CLK_NS = 40;

	// Whole refresh period in ms, shared across all rows
	localparam int REF_PERIOD_MS = 64;
	localparam int REF_ROWS = 1024;
	// Longest spacing between row refreshes, rounded down
	localparam int REF_GAP_CYC =
		(REF_PERIOD_MS * 1000000) / (REF_ROWS * CLK_NS);

	// Select high time to leave a burst, rounded up, at least one cycle
	localparam int BURST_EXIT_NS = 7;
	localparam int BURST_EXIT_CYC = (BURST_EXIT_NS + CLK_NS - 1) / CLK_NS;

	// Cycles the two-flop input synchroniser adds on read data
	localparam int SYNC_CYC = 2;

	// Bit positions of the cache bank field in the address
	localparam int BANK_LO = 8;
	localparam int BANK_HI = 9;

	// Reset value of the refresh row counter
	localparam logic [9:0] REF_ROW_RST = 10'h000;

	// User command codes
	typedef enum logic [1:0] {
		CDR_OP_READ = 2'h0,
		CDR_OP_WRITE = 2'h1
	} cdr_op_t;

	// One user request
	typedef struct packed {
		cdr_op_t op;
		logic [ADDR_W-1:0] row;
		logic [COL_W-1:0] col;
		logic [1:0] bank;
		logic burst;
		logic [2:0] order;
		logic mask_en;
		logic [DQ_W-1:0] mask;
		logic [DQ_W-1:0] data;
	} cdr_cmd_t;

	// Control pins driven toward the module; all strobes active low
	typedef struct packed {
		logic row_strobe_n;
		logic col_strobe_n;
		logic select_n;
		logic out_gate_n;
		logic write_en_n;
		logic write_read;
		logic refresh_n;
		logic burst_gate;
		logic [2:0] burst_order_select;
		logic output_hold_latch;
		logic [ADDR_W-1:0] addr;
	} cdr_pins_t;

	// Idle level of every control pin
	localparam cdr_pins_t PINS_IDLE = '{
		row_strobe_n: 1'b1, col_strobe_n: 1'b1, select_n: 1'b1,
		out_gate_n: 1'b1, write_en_n: 1'b1, write_read: 1'b0,
		refresh_n: 1'b1, burst_gate: 1'b0, burst_order_select: 3'h0,
		output_hold_latch: 1'b0, addr: 11'h000};

endpackage : cdr_pkg

/* File: rtl/cdr_host.sv */
// Host controller that drives a cached EDO DRAM module over its pins.
// Assumes the user port is on clk; read data pins arrive unsynchronised.
//
// How it works
// - Read column bits 8-9 pick the cache bank
// - Write column bits 8-9 copy row bits 8-9
// - Every row 0-1023 refreshed within 64 ms
// - Bit 10 held steady, not stepped, at refresh
// - Row-only refresh: write cycle without column strobe
// - Select high for exit time ends a burst
// - Burst gate level before column strobe picks burst
// - Burst order held stable around column strobe fall
// - Write mask on data lines at row strobe
`timescale 1ns/10ps
module cdr_host #(
	parameter int REF_GAP = cdr_pkg::REF_GAP_CYC,
	parameter int EXIT_CYC = cdr_pkg::BURST_EXIT_CYC
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic ref_use_pin,
	input wire logic cmd_valid,
	input wire cdr_pkg::cdr_cmd_t cmd,
	output logic cmd_ready,
	output logic rsp_valid,
	output logic [cdr_pkg::DQ_W-1:0] rsp_data,
	output logic rsp_hit,
	output cdr_pkg::cdr_pins_t pins,
	output logic [cdr_pkg::DQ_W-1:0] dq_out,
	output logic dq_oe,
	input wire logic [cdr_pkg::DQ_W-1:0] dq_in
);

	////////////////////////////////////////////////////////////////////////
	// Elaboration checks

	if (REF_GAP < 1 || REF_GAP > 65535)
		$error("REF_GAP outside counter range");
	if (EXIT_CYC < 1 || EXIT_CYC > 15)
		$error("EXIT_CYC outside counter range");

	////////////////////////////////////////////////////////////////////////
	// State machine, one-hot

	typedef enum logic [7:0] {
		ST_IDLE = 8'h01,
		ST_ROW = 8'h02,
		ST_COL = 8'h04,
		ST_RDWT = 8'h08,
		ST_PRE = 8'h10,
		ST_REFF = 8'h20,
		ST_REFR = 8'h40,
		ST_EXIT = 8'h80
	} cdr_state_t;

	cdr_state_t state_q, state_d; // Current and next state
	cdr_pkg::cdr_cmd_t cmd_q; // Request being served
	cdr_pkg::cdr_pins_t pins_d; // Pin levels for the next cycle
	logic [cdr_pkg::ADDR_W-1:0] lrr_q; // Last read row seen by the module
	logic lrr_ok_q; // Last read row holds a real value
	logic hit_q; // Current read is a cache hit
	logic [15:0] ref_cnt_q; // Cycles counted up since the last refresh tick
	logic ref_due_q; // A row refresh is owed
	logic [cdr_pkg::REF_ROW_W-1:0] ref_row_q; // Next row to refresh
	logic [3:0] wait_q; // Generic wait counter
	logic [cdr_pkg::DQ_W-1:0] dq_s1_q, dq_s2_q; // Read data synchroniser
	logic [cdr_pkg::DQ_W-1:0] dq_out_d; // Next data pin value
	logic dq_oe_d; // Next data pin enable

	////////////////////////////////////////////////////////////////////////
	// Decodes

	// Column address with the bank field in bits 8-9
	function automatic logic [cdr_pkg::ADDR_W-1:0] col_addr(
		input logic [1:0] bank,
		input logic [cdr_pkg::COL_W-1:0] col);
		col_addr = {1'b0, bank, col};
	endfunction : col_addr

	wire logic take_cmd = state_q == ST_IDLE && cmd_valid && cmd_ready;
	wire logic take_ref = state_q == ST_IDLE && ref_due_q && !take_cmd;
	wire logic is_rd = cmd_q.op == cdr_pkg::CDR_OP_READ;
	wire logic row_hit = lrr_ok_q && cmd.row == lrr_q;
	// Write bank comes from the row, never from the user bank field
	wire logic [1:0] wr_bank = cmd_q.row[cdr_pkg::BANK_HI:cdr_pkg::BANK_LO];
	wire logic [1:0] col_bank = is_rd ? cmd_q.bank : wr_bank;

	////////////////////////////////////////////////////////////////////////
	// Next state and next pin levels

	always_comb begin
		state_d = state_q;
		pins_d = cdr_pkg::PINS_IDLE;
		dq_out_d = '0;
		dq_oe_d = 1'b0;
		case (state_q)
			ST_IDLE: begin
				if (take_ref) begin
					// Ready drops one cycle after a refresh becomes owed, so no row ever starves
					state_d = ref_use_pin ? ST_REFF : ST_REFR;
				end else if (take_cmd) begin
					state_d = ST_ROW;
				end
			end
			ST_ROW: begin
				// Row strobe falls; mode pins set ahead of the column strobe
				pins_d.row_strobe_n = 1'b0;
				pins_d.select_n = 1'b0;
				pins_d.addr = cmd_q.row;
				pins_d.write_read = !is_rd;
				pins_d.burst_gate = cmd_q.burst;
				pins_d.burst_order_select = cmd_q.order;
				if (!is_rd && cmd_q.mask_en) begin
					dq_out_d = cmd_q.mask;
					dq_oe_d = 1'b1;
				end
				state_d = ST_COL;
			end
			ST_COL: begin
				// Column strobe falls with order and gate unchanged
				pins_d.row_strobe_n = 1'b0;
				pins_d.col_strobe_n = 1'b0;
				pins_d.select_n = 1'b0;
				pins_d.addr = col_addr(col_bank, cmd_q.col);
				pins_d.write_read = !is_rd;
				pins_d.burst_gate = cmd_q.burst;
				pins_d.burst_order_select = cmd_q.order;
				pins_d.write_en_n = is_rd;
				pins_d.out_gate_n = !is_rd;
				if (!is_rd) begin
					dq_out_d = cmd_q.data;
					dq_oe_d = 1'b1;
					state_d = ST_PRE;
				end else begin
					state_d = ST_RDWT;
				end
			end
			ST_RDWT: begin
				// Output latch held so the data stays put through sync
				pins_d = pins;
				pins_d.col_strobe_n = 1'b1;
				pins_d.output_hold_latch = 1'b1;
				if (wait_q == 4'h0) begin
					pins_d.row_strobe_n = 1'b1;
					// A hit skips the array precharge cycle
					if (cmd_q.burst) begin
						state_d = ST_EXIT;
					end else begin
						state_d = hit_q ? ST_IDLE : ST_PRE;
					end
				end
			end
			ST_PRE: begin
				// Row strobe high for the precharge
				if (cmd_q.burst && !take_ref) begin
					state_d = ST_EXIT;
				end else begin
					state_d = ST_IDLE;
				end
			end
			ST_EXIT: begin
				// Select already high from idle levels; hold it
				if (wait_q == 4'h0) begin
					state_d = ST_IDLE;
				end
			end
			ST_REFF: begin
				// Refresh pin low; other pins left at idle levels
				pins_d.refresh_n = 1'b0;
				state_d = ST_PRE;
			end
			ST_REFR: begin
				// Write cycle, row strobe only, bit 10 held low
				pins_d.row_strobe_n = 1'b0;
				pins_d.write_read = 1'b1;
				pins_d.addr = {1'b0, ref_row_q};
				state_d = ST_PRE;
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// State, pins and wait counter

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_q <= ST_IDLE;
			pins <= cdr_pkg::PINS_IDLE;
			dq_out <= '0;
			dq_oe <= 1'b0;
		end else if (ce) begin
			state_q <= state_d;
			pins <= pins_d;
			dq_out <= dq_out_d;
			dq_oe <= dq_oe_d;
		end
	end

	// Wait counter loaded on entry to read wait and burst exit
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wait_q <= 4'h0;
		end else if (ce) begin
			if (state_d == ST_RDWT && state_q != ST_RDWT) begin
				wait_q <= 4'(cdr_pkg::SYNC_CYC);
			end else if (state_d == ST_EXIT && state_q != ST_EXIT) begin
				wait_q <= 4'(EXIT_CYC - 1);
			end else if (wait_q != 4'h0) begin
				wait_q <= wait_q - 4'h1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Request capture and last read row tracking

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cmd_q <= '0;
			hit_q <= 1'b0;
			lrr_q <= '0;
			lrr_ok_q <= 1'b0;
		end else if (ce) begin
			if (take_cmd) begin
				cmd_q <= cmd;
				hit_q <= cmd.op == cdr_pkg::CDR_OP_READ && row_hit;
				if (cmd.op == cdr_pkg::CDR_OP_READ) begin
					lrr_q <= cmd.row;
					lrr_ok_q <= 1'b1;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Ready flag; low while busy, or from one cycle after a refresh becomes owed

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cmd_ready <= 1'b0;
		end else if (ce) begin
			cmd_ready <= state_d == ST_IDLE && !ref_due_q;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Refresh pacing: one row each gap, rows walked in order

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ref_cnt_q <= 16'h0000;
			ref_due_q <= 1'b0;
			ref_row_q <= cdr_pkg::REF_ROW_RST;
		end else if (ce) begin
			if (ref_cnt_q == 16'(REF_GAP - 1)) begin
				ref_cnt_q <= 16'h0000;
			end else begin
				ref_cnt_q <= ref_cnt_q + 16'h0001;
			end
			// A new tick wins over the clear in the same cycle
			if (ref_cnt_q == 16'(REF_GAP - 1)) begin
				ref_due_q <= 1'b1;
			end else if (take_ref) begin
				ref_due_q <= 1'b0;
			end
			if (take_ref) begin
				ref_row_q <= ref_row_q + 10'h001;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read data: two flops before use, captured at the end of the wait

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			dq_s1_q <= '0;
			dq_s2_q <= '0;
			rsp_valid <= 1'b0;
			rsp_data <= '0;
			rsp_hit <= 1'b0;
		end else if (ce) begin
			dq_s1_q <= dq_in;
			dq_s2_q <= dq_s1_q;
			rsp_valid <= state_q == ST_RDWT && wait_q == 4'h0;
			if (state_q == ST_RDWT && wait_q == 4'h0) begin
				rsp_data <= dq_s2_q;
				rsp_hit <= hit_q;
			end
		end
	end

endmodule : cdr_host

/* File: sim/cdr_assertions.sv */
// Port checker for the cached DRAM host controller.
// Assumes it is bound onto cdr_host; one clock, async reset.
`timescale 1ns/10ps
module cdr_assertions #(
	parameter int REF_GAP = cdr_pkg::REF_GAP_CYC,
	parameter int EXIT_CYC = cdr_pkg::BURST_EXIT_CYC
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic ref_use_pin,
	input wire logic cmd_valid,
	input wire cdr_pkg::cdr_cmd_t cmd,
	input wire logic cmd_ready,
	input wire logic rsp_valid,
	input wire logic [cdr_pkg::DQ_W-1:0] rsp_data,
	input wire logic rsp_hit,
	input wire cdr_pkg::cdr_pins_t pins,
	input wire logic [cdr_pkg::DQ_W-1:0] dq_out,
	input wire logic dq_oe,
	input wire logic [cdr_pkg::DQ_W-1:0] dq_in
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	wire rd = cmd_valid && cmd_ready && cmd.op == cdr_pkg::CDR_OP_READ;
	wire wr = cmd_valid && cmd_ready && cmd.op == cdr_pkg::CDR_OP_WRITE;
	int gap_q; // Cycles since a refresh; writes restart it too, a weakness
	////////////////////////////////////////////////////////////////////////
	// Refresh spacing counter
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			gap_q <= 0;
		else if (!pins.refresh_n || !pins.row_strobe_n && pins.write_read)
			gap_q <= 0;
		else
			gap_q <= gap_q + 1;
	end
	read_bank_a: assert property (
		rd |-> ##3 !pins.col_strobe_n && pins.addr[9:8] == $past(cmd.bank, 3))
		else $error("read bank field wrong");
	write_bank_a: assert property (
		wr |-> ##3 !pins.write_en_n
		&& pins.addr[9:8] == $past(cmd.row[9:8], 3))
		else $error("write bank differs from row");
	rsp_time_a: assert property (
		rd |-> !rsp_valid [*6] ##1 rsp_valid)
		else $error("read answer late or early");
	pin_ref_a: assert property (
		$fell(pins.refresh_n) |-> pins.row_strobe_n ##1 pins.refresh_n)
		else $error("pin refresh shape wrong");
	row_ref_a: assert property (
		$fell(pins.row_strobe_n) && pins.write_read && pins.write_en_n
		##1 pins.col_strobe_n |-> !$past(pins.addr[10]) && pins.write_en_n)
		else $error("row refresh shape wrong");
	ref_gap_a: assert property (gap_q <= REF_GAP + 16)
		else $error("refresh gap too long");
	burst_gate_a: assert property (
		rd |-> ##2 pins.burst_gate == $past(cmd.burst, 2))
		else $error("burst gate level wrong");
	order_a: assert property (
		rd |-> ##2 pins.burst_order_select == $past(cmd.order, 2))
		else $error("burst order not held");
	hold_a: assert property (
		$rose(pins.col_strobe_n) && !$past(pins.write_read)
		|-> pins.output_hold_latch) else $error("output not held");
	mask_a: assert property (
		wr && cmd.mask_en |-> ##2 !pins.row_strobe_n && dq_oe
		&& dq_out == $past(cmd.mask, 2)) else $error("mask not driven");
	exit_a: assert property (
		rd && cmd.burst |-> ##7 pins.select_n [*2])
		else $error("burst exit missing");
	cover property (rsp_valid && rsp_hit);
	cover property ($fell(pins.refresh_n));
	cover property (rd && cmd.burst);
endmodule : cdr_assertions
bind cdr_host cdr_assertions #(.REF_GAP(REF_GAP), .EXIT_CYC(EXIT_CYC))
	i_cdr_assertions (.clk(clk), .rst(rst), .ce(ce),
	.ref_use_pin(ref_use_pin), .cmd_valid(cmd_valid), .cmd(cmd),
	.cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
	.rsp_hit(rsp_hit), .pins(pins), .dq_out(dq_out), .dq_oe(dq_oe),
	.dq_in(dq_in));

/* File: sim/cdr_dram_model.sv */
// Behavioural cached DRAM module on the host's pins.
// Assumes registered pins; the module has no clock of its own.
`timescale 1ns/10ps
module cdr_dram_model (
	input wire cdr_pkg::cdr_pins_t pins,
	input wire logic [cdr_pkg::DQ_W-1:0] dq_out,
	input wire logic dq_oe,
	output logic [cdr_pkg::DQ_W-1:0] dq_in
);
	bit [71:0] mem [bit [18:0]]; // Words by row and column
	bit [10:0] bank_row [4]; // Row held by each cache bank
	bit [10:0] row_q; // Active row for writes
	bit [71:0] mask_q; // Write-per-bit mask
	bit [71:0] q_q; // Output latch
	////////////////////////////////////////////////////////////////////////
	// Row strobe: latch row and mask, fill a bank on reads
	// Data lines settle in the same step as the strobe, so look just after
	always @(negedge pins.row_strobe_n) begin
		#1;
		if (pins.refresh_n) begin
			row_q = pins.addr;
			mask_q = dq_oe ? dq_out : '1;
			if (!pins.write_read)
				bank_row[pins.addr[9:8]] = pins.addr;
		end
	end
	// Writes land in the active row only
	always @(negedge pins.write_en_n) begin
		#1;
		if (pins.refresh_n)
			mem[{row_q, pins.addr[7:0]}] =
				mem[{row_q, pins.addr[7:0]}] & ~mask_q | dq_out & mask_q;
	end
	// Cache read from any bank, also during a pin refresh
	always @(negedge pins.col_strobe_n) begin
		if (!pins.write_read && !pins.output_hold_latch)
			q_q = mem[{bank_row[pins.addr[9:8]], pins.addr[7:0]}];
	end
	// A released bus shows the inverse, never the last word
	assign dq_in = pins.out_gate_n ? ~q_q : q_q;
endmodule : cdr_dram_model

/* File: sim/test_cached_dram_access_refresh.sv */
// Self-checking bench for the cached DRAM host controller.
// Assumes package, host, checker and module model compile first.
`timescale 1ns/10ps
module test_cached_dram_access_refresh;
	localparam int CW = $bits(cdr_pkg::cdr_cmd_t);
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic ref_use_pin = 1'b1;
	logic cmd_valid = 1'b0;
	cdr_pkg::cdr_cmd_t cmd = '0;
	logic cmd_ready, rsp_valid, rsp_hit, dq_oe;
	logic [cdr_pkg::DQ_W-1:0] rsp_data, dq_out, dq_in;
	cdr_pkg::cdr_pins_t pins;
	int mismatches = 0;
	int samples_checked = 0;
	bit [71:0] mem [bit [18:0]]; // Expected array contents
	bit [10:0] bank_row [4]; // Expected row per cache bank
	bit [10:0] last_row; // Row of the latest read
	bit seen; // A read has happened
	// Short refresh spacing keeps the run brief
	cdr_host #(.REF_GAP(20), .EXIT_CYC(1)) i_cdr_host (.clk(clk),
		.rst(rst), .ce(1'b1), .ref_use_pin(ref_use_pin),
		.cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready),
		.rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_hit(rsp_hit),
		.pins(pins), .dq_out(dq_out), .dq_oe(dq_oe), .dq_in(dq_in));
	cdr_dram_model i_cdr_dram_model (.pins(pins), .dq_out(dq_out),
		.dq_oe(dq_oe), .dq_in(dq_in));
	initial forever #20 clk = ~clk;
	////////////////////////////////////////////////////////////////////////
	task automatic summarize();
		if (mismatches == 0 && samples_checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : summarize
	task automatic cmp_word(input logic [71:0] got, input logic [71:0] exp);
		samples_checked++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp_word
	task automatic cmp_flag(input logic got, input logic exp);
		cmp_word({71'h0, got}, {71'h0, exp});
	endtask : cmp_flag
	// Hold the request until the edge that samples ready high
	task automatic issue(input cdr_pkg::cdr_cmd_t c);
		int n;
		n = 0;
		cmd <= c;
		cmd_valid <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (cmd_ready !== 1'b1 && n < 200);
		cmd_valid <= 1'b0;
		if (n >= 200)
			mismatches++;
		@(posedge clk);
	endtask : issue
	function automatic bit [71:0] exp_read(input cdr_pkg::cdr_cmd_t c);
		bank_row[c.row[9:8]] = c.row;
		return mem[{bank_row[c.bank], c.col}];
	endfunction : exp_read
	function automatic bit exp_hit(input bit [10:0] row);
		exp_hit = seen && row == last_row;
		seen = 1'b1;
		last_row = row;
	endfunction : exp_hit
	task automatic wr(input cdr_pkg::cdr_cmd_t c);
		bit [18:0] k;
		k = {c.row, c.col};
		c.op = cdr_pkg::CDR_OP_WRITE;
		mem[k] = c.mask_en ? mem[k] & ~c.mask | c.data & c.mask : c.data;
		issue(c);
	endtask : wr
	task automatic rd(input cdr_pkg::cdr_cmd_t c);
		bit h;
		bit [71:0] d;
		int n;
		c.op = cdr_pkg::CDR_OP_READ;
		h = exp_hit(c.row);
		d = exp_read(c);
		issue(c);
		n = 0;
		while (rsp_valid !== 1'b1 && n < 20) begin
			@(posedge clk);
			n++;
		end
		if (n >= 20)
			mismatches++;
		cmp_word(rsp_data, d);
		cmp_flag(rsp_hit, h);
	endtask : rd
	////////////////////////////////////////////////////////////////////////
	// Top row and column first, then random traffic in both refresh styles
	initial begin
		cdr_pkg::cdr_cmd_t c;
		void'($urandom(64733));
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		repeat (2) @(posedge clk);
		c = '0;
		c.row = 11'h7ff;
		c.col = 8'hff;
		c.bank = 2'h3;
		c.data = '1;
		wr(c);
		rd(c);
		for (int i = 0; i < 40; i++) begin
			c = CW'({$urandom, $urandom, $urandom, $urandom, $urandom,
				$urandom});
			c.row[7:0] = 8'h00;
			if (i == 20)
				ref_use_pin <= 1'b0;
			wr(c);
			rd(c);
			c.bank = c.row[9:8];
			rd(c);
		end
		summarize();
	end
	// About 1000 cycles are expected; allow fifteen times that
	initial begin
		repeat (15000) @(posedge clk);
		mismatches++;
		summarize();
	end
endmodule : test_cached_dram_access_refresh
